/* File: testbench/testbench.sv */
// self-checking bench: apb master, host model on the serial link
// assumes DEV_RST_CYC shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vrhi_pkg::*;
    logic clk, rstn, psel, pen, pwr, tick, sdo, drst, sclk, mosi, sel_n;
    logic pready, pslverr, miso, miso_oe, rdy, irq, irqn, irqn_oe, err, b;
    logic [7:0] paddr, gin, gout, goe;
    logic [31:0] pwd, prdata, rd, r;
    logic [1:0] spk;
    logic [23:0] faddr;
    vrhi_cfg_t cfg;
    int n_mismatch, n_checks, n_busy;
    vrhi_top #(.DEV_RST_CYC(20)) dut (.REF_CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(1'b1),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwd), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata),
        .SCLK_IN(sclk), .MOSI_IN(mosi), .TARGET_SELECT_N_IN(sel_n), .MISO_OUT(miso),
        .MISO_OE_OUT(miso_oe), .TRANSFER_READY_OUT(rdy), .IRQ_OUT(irq),
        .IRQ_REQUEST_N_OUT(irqn), .IRQ_REQUEST_N_OE_OUT(irqn_oe), .DEV_RESET_IN(drst),
        .GPIO_IN(gin), .GPIO_OUT_OUT(gout), .GPIO_OE_OUT(goe), .I2S_SDO_BIT_IN(sdo),
        .SAMPLE_TICK_IN(tick), .SPK_OE_OUT(spk), .FLASH_ADDR_OUT(faddr),
        .AUDIO_CFG_OUT(cfg));
    vrhi_host_model host (.clk(clk), .miso(miso), .miso_oe(miso_oe), .ready(rdy),
        .sclk(sclk), .mosi(mosi), .sel_n(sel_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) n_busy <= n_busy + int'(rdy === 1'b0);
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        host.xfer(16, {op, d, 16'h0}, r);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic t_reset;
        chk(cfg === CFG_RST && irqn === 1'b1 && irqn_oe === 1'b0, "reset cfg");
        chk(miso_oe === 1'b0 && rdy === 1'b1, "idle miso/ready");
        chk(spk === 2'b11, "speakers on");
    endtask
    task automatic t_volume;
        int nb;
        nb = n_busy;
        for (int i = 0; i < 3; i++) cmd(8'(OP_VOL_IN + i), 8'(8'h11 * (i + 1)));
        chk(n_busy > nb, "never busy");
        chk(cfg.vol_in === 8'h11 && cfg.vol_pb === 8'h22 && cfg.vol_master === 8'h33, "vol");
        apb(1'b0, A_VOLUME, 32'h0);
        chk(rd === 32'h00332211 && err === 1'b0, "vol reg");
        for (int g = 0; g < 4; g++) begin
            cmd(OP_AUX_GAIN, 8'(g));
            chk(cfg.aux_gain === 2'(g), "gain");
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped");
    endtask
    task automatic t_format;
        logic [7:0] ok[6] = '{8'h02, 8'h17, 8'h28, 8'h3c, 8'h3a, 8'h05};
        logic [7:0] bad[3] = '{8'h06, 8'h3b, 8'h29};
        foreach (ok[i]) begin
            cmd(OP_FORMAT, ok[i]);
            chk(cfg.codec === vrhi_codec_t'(ok[i][5:4]) && cfg.bits === ok[i][3:0], "fmt");
        end
        foreach (bad[i]) cmd(OP_FORMAT, bad[i]);
        chk(cfg.codec === CK_ADPCM && cfg.bits === 4'h5, "bad fmt taken");
        for (int k = 0; k < 7; k++) begin
            cmd(OP_RATE, 8'(((k % 3) << 4) | k));
            chk(cfg.rate === 3'(k) && cfg.mrate === 2'(k % 3), "rate");
        end
        cmd(OP_RATE, 8'h07);
        cmd(OP_RATE, 8'h30);
        chk(cfg.rate === 3'h6 && cfg.mrate === 2'h0, "bad rate taken");
    endtask
    task automatic t_irq;
        apb(1'b1, A_IRQ_STAT, 32'h7);
        apb(1'b1, A_IRQ_MASK, 32'h0);
        cmd(OP_FORMAT, 8'h06);
        b = irq;
        chk(irqn === ~irq && irqn_oe === irq, "irq pin");
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(rd === 32'h4, "cfg err");
        host.xfer(16, {OP_RD_STAT, 24'h0}, r);
        chk(r[7:0] === 8'h20, "status byte");
        apb(1'b1, A_IRQ_MASK, 32'h7);
        repeat (3) @(posedge clk);
        chk((irq ^ b) === 1'b1 && irqn === ~irq && irqn_oe === irq, "mask");
        apb(1'b1, A_IRQ_STAT, 32'h4);
        repeat (3) @(posedge clk);
        chk(irq === 1'b0 && irqn === 1'b1 && irqn_oe === 1'b0, "clear");
    endtask
    task automatic t_abort;
        cmd(OP_VOL_IN, 8'h44);
        host.xfer(12, {OP_VOL_IN, 8'hee, 16'h0}, r);
        repeat (5) @(posedge clk);
        chk(cfg.vol_in === 8'h44 && miso_oe === 1'b0, "abort");
        cmd(OP_VOL_IN, 8'h55);
        chk(cfg.vol_in === 8'h55, "after abort");
    endtask
    task automatic t_rec;
        cmd(OP_FORMAT, 8'h04);
        apb(1'b1, A_IRQ_STAT, 32'h7);
        cmd(OP_REC_START, 8'h0);
        ticks(4);
        cmd(OP_REC_STOP, 8'h0);
        apb(1'b0, A_REC_ADDR, 32'h0);
        chk(rd === 32'h0, "rec addr 0");
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(rd[0] === 1'b1, "rec done");
        cmd(OP_REC_START, 8'h0);
        ticks(3);
        cmd(OP_REC_STOP, 8'h0);
        apb(1'b0, A_REC_ADDR, 32'h0);
        chk(rd === 32'h2 && faddr === 24'h4, "rec addr 2");
        host.xfer(32, {OP_RD_ADDR, 24'h0}, r);
        chk(r[23:0] === 24'h2, "serial addr");
    endtask
    task automatic t_gpio;
        int n;
        n = 0;
        apb(1'b1, A_CTRL, 32'h6);
        repeat (4) @(posedge clk);
        chk(goe[7:4] === 4'b0111 && cfg.rec_i2s === 1'b1, "i2s master");
        b = gout[6];
        repeat (16) begin
            @(posedge clk);
            if (gout[6] !== b) n++;
            b = gout[6];
        end
        chk(n == 4, "bit clock");
        apb(1'b1, A_CTRL, 32'h2);
        sdo <= 1'b1;
        repeat (4) @(posedge clk);
        chk(goe[7:4] === 4'b0001 && gout[4] === 1'b1, "i2s slave");
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_GPIO_OE, 32'ha5);
        apb(1'b1, A_GPIO_OUT, 32'h5a);
        gin <= 8'h3c;
        repeat (4) @(posedge clk);
        chk(goe === 8'ha5 && gout === 8'h5a && cfg.rec_i2s === 1'b0, "gpio");
        apb(1'b0, A_GPIO_IN, 32'h0);
        chk(rd === 32'h3c, "gpio in");
        apb(1'b1, A_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk(spk === 2'b00, "power down");
        apb(1'b1, A_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk(spk === 2'b11, "power up");
    endtask
    task automatic t_devrst;
        cmd(OP_VOL_IN, 8'h11);
        drst <= 1'b1;
        repeat (10) @(posedge clk);
        drst <= 1'b0;
        repeat (5) @(posedge clk);
        chk(cfg.vol_in === 8'h11, "short pulse");
        drst <= 1'b1;
        repeat (30) @(posedge clk);
        drst <= 1'b0;
        repeat (5) @(posedge clk);
        chk(cfg === CFG_RST, "long pulse");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {rstn, psel, pen, pwr, tick, sdo, drst} = '0;
        {paddr, gin, pwd} = '0;
        {n_mismatch, n_checks, n_busy} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset;
        t_volume;
        t_format;
        t_irq;
        t_abort;
        t_rec;
        t_gpio;
        t_devrst;
        test_done;
    end
    initial begin
        #500000;
        n_mismatch++;
        test_done;
    end
endmodule
`default_nettype wire

/* File: testbench/vrhi_host_model.sv */
// host model: master of the serial command link
// assumes mode 0 framing, sampled on a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module vrhi_host_model (
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic ready,
    output logic sclk,
    output logic mosi,
    output logic sel_n
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        sel_n = 1'b1;
    end
    // sends nbits msb first from tx, returns bits seen at each rise
    task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        while (ready !== 1'b1) begin
            @(posedge clk);
        end
        @(posedge clk);
        sel_n <= 1'b0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            mosi <= tx[31-i];
            repeat (5) @(posedge clk);
            sclk <= 1'b1;
            rx = {rx[30:0], miso_oe ? miso : 1'bx};
            repeat (5) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        sel_n <= 1'b1;
        mosi <= ~mosi;
    endtask
endmodule
`default_nettype wire

/* File: verilog/vrhi_pkg.sv */
// constants, types and helpers for the voice recorder host interface
// assumes a single 100 MHz clock domain
package vrhi_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int RST_HOLD_MS = 50;
    localparam int RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
    localparam int BUSY_NS = 80;
    localparam logic [3:0] BUSY_CYC = 4'((BUSY_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    localparam int BCLK_HALF_NS = 40;
    localparam logic [2:0] BCLK_LAST = 3'((BCLK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000 - 1);
    localparam logic [4:0] WS_LAST = 5'h1f;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQ_STAT = 8'h08;
    localparam logic [7:0] A_IRQ_MASK = 8'h0c;
    localparam logic [7:0] A_VOLUME = 8'h10;
    localparam logic [7:0] A_AUDIO = 8'h14;
    localparam logic [7:0] A_REC_ADDR = 8'h18;
    localparam logic [7:0] A_FLASH_ADDR = 8'h1c;
    localparam logic [7:0] A_GPIO_OUT = 8'h20;
    localparam logic [7:0] A_GPIO_OE = 8'h24;
    localparam logic [7:0] A_GPIO_IN = 8'h28;

    localparam int C_PD = 0;
    localparam int C_I2S = 1;
    localparam int C_MST = 2;
    localparam int EV_REC_DONE = 0;
    localparam int EV_MEM_FULL = 1;
    localparam int EV_CFG_ERR = 2;

    localparam logic [7:0] OP_NONE = 8'h00;
    localparam logic [7:0] OP_VOL_IN = 8'h01;
    localparam logic [7:0] OP_VOL_PB = 8'h02;
    localparam logic [7:0] OP_VOL_MASTER = 8'h03;
    localparam logic [7:0] OP_AUX_GAIN = 8'h04;
    localparam logic [7:0] OP_FORMAT = 8'h05;
    localparam logic [7:0] OP_RATE = 8'h06;
    localparam logic [7:0] OP_REC_START = 8'h10;
    localparam logic [7:0] OP_REC_STOP = 8'h11;
    localparam logic [7:0] OP_RD_ADDR = 8'h20;
    localparam logic [7:0] OP_RD_STAT = 8'h21;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] BYTE_LAST = 2'h3;

    localparam int FMT_KIND_LSB = 4;
    localparam int FMT_KIND_MSB = 5;
    localparam int FMT_BITS_MSB = 3;
    localparam int RATE_MSB = 2;
    localparam int MRATE_LSB = 4;
    localparam int MRATE_MSB = 5;

    localparam logic [3:0] ADPCM_MIN = 4'h2;
    localparam logic [3:0] ADPCM_MAX = 4'h5;
    localparam logic [3:0] LAW_MIN = 4'h6;
    localparam logic [3:0] LAW_MAX = 4'h8;
    localparam logic [3:0] PCM_LO = 4'h8;
    localparam logic [3:0] PCM_MID = 4'ha;
    localparam logic [3:0] PCM_HI = 4'hc;
    localparam logic [2:0] RATE_CNT = 3'h7;
    localparam logic [1:0] MRATE_CNT = 2'h3;
    localparam logic [27:0] FLASH_BITS = 28'h800_0000;

    typedef enum logic [1:0] {
        CK_ADPCM = 2'h0,
        CK_ULAW = 2'h1,
        CK_DULAW = 2'h2,
        CK_PCM = 2'h3
    } vrhi_codec_t;

    typedef struct packed {
        logic [7:0] vol_in;
        logic [7:0] vol_pb;
        logic [7:0] vol_master;
        logic [1:0] aux_gain;
        vrhi_codec_t codec;
        logic [3:0] bits;
        logic [2:0] rate;
        logic [1:0] mrate;
        logic rec_i2s;
    } vrhi_cfg_t;

    localparam vrhi_cfg_t CFG_RST = '{vol_in: 8'h80, vol_pb: 8'h80, vol_master: 8'h80,
        aux_gain: 2'h0, codec: CK_ADPCM, bits: 4'h4, rate: 3'h3, mrate: 2'h0, rec_i2s: 1'b0};

    function automatic logic cfg_ok(vrhi_cfg_t c);
        logic b;
        unique case (c.codec)
            CK_ADPCM: b = (c.bits >= ADPCM_MIN) && (c.bits <= ADPCM_MAX);
            CK_ULAW, CK_DULAW: b = (c.bits >= LAW_MIN) && (c.bits <= LAW_MAX);
            CK_PCM: b = (c.bits == PCM_LO) || (c.bits == PCM_MID) || (c.bits == PCM_HI);
        endcase
        return b && (c.rate < RATE_CNT) && (c.mrate < MRATE_CNT);
    endfunction
endpackage

/* File: verilog/vrhi_top.sv */
// host interface of the voice recorder: serial command link, apb registers,
// ready and interrupt pins, long-pulse reset, gpio/i2s sharing, recording pointer
// assumes apb master and audio path on REF_CLK_IN; serial pins are asynchronous
//
// Functional notes
// - miso released while target deselected
// - serial commands honoured only while selected
// - ready high only when a command can be accepted
// - 50 ms high reset pin resets device
// - interrupt pulls open-drain pin low
// - eight gpio, four shared with i2s
// - i2s clocks out as master, in slave
// - three 8-bit volumes written by command
// - 2-bit auxiliary input gain by command
// - speaker outputs released while powered down
// - allocate storage, report recording start address
// - adpcm, companding and pcm bit widths
// - seven rates, three i2s master rates
// - i2s input replaces analog recording source
// - flash addressing covers 128 megabits
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vrhi_top #(
    parameter int DEV_RST_CYC = vrhi_pkg::RST_HOLD_CYC
) (
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic CE_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic [31:0] PRDATA_OUT,
    input wire logic SCLK_IN,
    input wire logic MOSI_IN,
    input wire logic TARGET_SELECT_N_IN,
    output logic MISO_OUT,
    output logic MISO_OE_OUT,
    output logic TRANSFER_READY_OUT,
    output logic IRQ_OUT,
    output logic IRQ_REQUEST_N_OUT,
    output logic IRQ_REQUEST_N_OE_OUT,
    input wire logic DEV_RESET_IN,
    input wire logic [7:0] GPIO_IN,
    output logic [7:0] GPIO_OUT_OUT,
    output logic [7:0] GPIO_OE_OUT,
    input wire logic I2S_SDO_BIT_IN,
    input wire logic SAMPLE_TICK_IN,
    output logic [1:0] SPK_OE_OUT,
    output logic [23:0] FLASH_ADDR_OUT,
    output vrhi_pkg::vrhi_cfg_t AUDIO_CFG_OUT
);
    import vrhi_pkg::*;

    localparam int PIN_SDO = 4;
    localparam int PIN_WS = 5;
    localparam int PIN_SCK = 6;
    localparam int PIN_SDI = 7;
    localparam logic [1:0] SPK_ON = 2'h3;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic mosi_s1;
        logic mosi_s2;
        logic ss_s1;
        logic ss_s2;
        logic rst_s1;
        logic rst_s2;
        logic [7:0] gpio_s1;
        logic [7:0] gpio_s2;
    } vrhi_sync_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } vrhi_bus_t;

    typedef struct packed {
        vrhi_sync_t pins;
        vrhi_bus_t bus;
        logic [31:0] hold_cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] opcode;
        logic [3:0] busy;
        logic [2:0] ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        vrhi_cfg_t cfg;
        logic rec;
        logic [26:0] ptr;
        logic [23:0] start;
        logic [23:0] rec_addr;
        logic [7:0] gpio_o;
        logic [7:0] gpio_oe;
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
        logic [2:0] bdiv;
        logic bclk;
        logic [4:0] wscnt;
        logic ws;
        logic [1:0] spk_oe;
        logic miso_oe;
        logic ready;
        logic irq;
        logic irq_n;
    } vrhi_state_t;

    localparam vrhi_sync_t SYNC_RST = '{ss_s1: 1'b1, ss_s2: 1'b1, default: '0};
    localparam vrhi_state_t S_RST = '{pins: SYNC_RST, cfg: CFG_RST, irq_n: 1'b1, default: '0};

    // next byte boundary, so each recording starts on a whole flash byte
    function automatic logic [26:0] round_up(logic [26:0] p);
        return {p[26:3] + 24'(|p[2:0]), 3'h0};
    endfunction

    logic [1:0] rst_q;
    logic rst_n;
    vrhi_state_t r;
    vrhi_state_t n;
    vrhi_state_t k;
    logic sel;
    logic rise;
    logic acc;
    logic hit;
    logic dev_hold;
    logic master;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [7:0] rx;
    logic [7:0] op;
    logic [1:0] idx;
    logic [27:0] nxt_ptr;
    logic [31:0] rd;
    vrhi_cfg_t c;

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_q <= '0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    always_comb begin
        n = r;
        k = r;
        ev = '0;
        clr = '0;
        hit = 1'b1;
        rd = '0;
        c = r.cfg;
        n.pins.sclk_s1 = SCLK_IN;
        n.pins.sclk_s2 = r.pins.sclk_s1;
        n.pins.sclk_d = r.pins.sclk_s2;
        n.pins.mosi_s1 = MOSI_IN;
        n.pins.mosi_s2 = r.pins.mosi_s1;
        n.pins.ss_s1 = TARGET_SELECT_N_IN;
        n.pins.ss_s2 = r.pins.ss_s1;
        n.pins.rst_s1 = DEV_RESET_IN;
        n.pins.rst_s2 = r.pins.rst_s1;
        n.pins.gpio_s1 = GPIO_IN;
        n.pins.gpio_s2 = r.pins.gpio_s1;
        sel = !r.pins.ss_s2;
        rise = r.pins.sclk_s2 & ~r.pins.sclk_d;
        acc = PSEL_IN & PENABLE_IN;
        dev_hold = r.hold_cnt >= 32'(DEV_RST_CYC);
        master = r.ctrl[C_I2S] & r.ctrl[C_MST];
        if (r.busy != '0) begin
            n.busy = r.busy - 4'h1;
        end

        // sample accounting while recording
        nxt_ptr = {1'b0, r.ptr} + 28'(r.cfg.bits);
        if (r.rec && SAMPLE_TICK_IN) begin
            if (nxt_ptr >= FLASH_BITS) begin
                n.rec = 1'b0;
                n.rec_addr = r.start;
                ev[EV_REC_DONE] = 1'b1;
                ev[EV_MEM_FULL] = 1'b1;
            end else begin
                n.ptr = nxt_ptr[26:0];
            end
        end

        // serial command link, mode 0, msb first
        rx = {r.rx_sh[6:0], r.pins.mosi_s2};
        op = (r.byte_cnt == '0) ? (r.ready ? rx : OP_NONE) : r.opcode;
        idx = r.byte_cnt + 2'h1;
        if (!sel) begin
            n.bit_cnt = '0;
            n.byte_cnt = '0;
            n.tx_sh = '0;
        end else if (rise) begin
            n.rx_sh = rx;
            n.bit_cnt = r.bit_cnt + 3'h1;
            n.tx_sh = {r.tx_sh[6:0], 1'b0};
            if (r.bit_cnt == LAST_BIT) begin
                if (r.byte_cnt != BYTE_LAST) begin
                    n.byte_cnt = idx;
                end
                if (r.byte_cnt == '0) begin
                    n.opcode = op;
                    if (op == OP_REC_START && !r.rec) begin
                        n.rec = 1'b1;
                        n.start = r.ptr[26:3];
                        n.busy = BUSY_CYC;
                    end
                    if (op == OP_REC_STOP && r.rec) begin
                        n.rec = 1'b0;
                        n.rec_addr = r.start;
                        n.ptr = round_up(n.ptr);
                        ev[EV_REC_DONE] = 1'b1;
                        n.busy = BUSY_CYC;
                    end
                end else if (r.byte_cnt == 2'h1) begin
                    unique case (op)
                        OP_VOL_IN: c.vol_in = rx;
                        OP_VOL_PB: c.vol_pb = rx;
                        OP_VOL_MASTER: c.vol_master = rx;
                        OP_AUX_GAIN: c.aux_gain = rx[1:0];
                        OP_FORMAT: begin
                            c.codec = vrhi_codec_t'(rx[FMT_KIND_MSB:FMT_KIND_LSB]);
                            c.bits = rx[FMT_BITS_MSB:0];
                        end
                        OP_RATE: begin
                            c.rate = rx[RATE_MSB:0];
                            c.mrate = rx[MRATE_MSB:MRATE_LSB];
                        end
                        default: ;
                    endcase
                    if (op != OP_NONE) begin
                        n.busy = BUSY_CYC;
                    end
                end
                if (op == OP_RD_ADDR) begin
                    unique case (idx)
                        2'h0: n.tx_sh = '0;
                        2'h1: n.tx_sh = r.rec_addr[23:16];
                        2'h2: n.tx_sh = r.rec_addr[15:8];
                        2'h3: n.tx_sh = r.rec_addr[7:0];
                    endcase
                end else if (op == OP_RD_STAT && idx == 2'h1) begin
                    n.tx_sh = {2'h0, r.irq_stat, r.rec, r.ctrl[C_I2S], r.ctrl[C_PD]};
                end
            end
        end
        // an illegal format or rate is refused and flagged
        if (cfg_ok(c)) begin
            n.cfg = c;
        end else begin
            ev[EV_CFG_ERR] = 1'b1;
        end

        // apb slave, one wait state
        unique case (PADDR_IN)
            A_CTRL: rd = 32'(r.ctrl);
            A_STATUS: rd = 32'({r.rec, r.ready, sel});
            A_IRQ_STAT: rd = 32'(r.irq_stat);
            A_IRQ_MASK: rd = 32'(r.irq_mask);
            A_VOLUME: rd = 32'({r.cfg.vol_master, r.cfg.vol_pb, r.cfg.vol_in});
            A_AUDIO: rd = 32'({r.cfg.mrate, r.cfg.rate, r.cfg.bits, r.cfg.codec,
                r.cfg.aux_gain});
            A_REC_ADDR: rd = 32'(r.rec_addr);
            A_FLASH_ADDR: rd = 32'(r.ptr[26:3]);
            A_GPIO_OUT: rd = 32'(r.gpio_o);
            A_GPIO_OE: rd = 32'(r.gpio_oe);
            A_GPIO_IN: rd = 32'(r.pins.gpio_s2);
            default: hit = 1'b0;
        endcase
        n.bus.pready = acc & ~r.bus.pready;
        n.bus.pslverr = acc & ~r.bus.pready & ~hit;
        n.bus.prdata = (acc && !r.bus.pready && !PWRITE_IN) ? rd : '0;
        if (acc && r.bus.pready && PWRITE_IN) begin
            unique case (PADDR_IN)
                A_CTRL: n.ctrl = PWDATA_IN[2:0];
                A_IRQ_STAT: clr = PWDATA_IN[2:0];
                A_IRQ_MASK: n.irq_mask = PWDATA_IN[2:0];
                A_GPIO_OUT: n.gpio_o = PWDATA_IN[7:0];
                A_GPIO_OE: n.gpio_oe = PWDATA_IN[7:0];
                default: ;
            endcase
        end
        // a new event beats a clear in the same cycle
        n.irq_stat = (r.irq_stat & ~clr) | ev;
        n.cfg.rec_i2s = n.ctrl[C_I2S];

        // i2s master clock generation
        if (master) begin
            if (r.bdiv == BCLK_LAST) begin
                n.bdiv = '0;
                n.bclk = ~r.bclk;
                if (r.bclk) begin
                    n.wscnt = r.wscnt + 5'h1;
                    if (r.wscnt == WS_LAST) begin
                        n.ws = ~r.ws;
                    end
                end
            end else begin
                n.bdiv = r.bdiv + 3'h1;
            end
        end else begin
            n.bdiv = '0;
            n.bclk = 1'b0;
            n.wscnt = '0;
            n.ws = 1'b0;
        end
        n.pin_o = r.gpio_o;
        n.pin_oe = r.gpio_oe;
        if (r.ctrl[C_I2S]) begin
            n.pin_oe[PIN_SDI] = 1'b0;
            n.pin_o[PIN_SDI] = 1'b0;
            n.pin_oe[PIN_SCK] = master;
            n.pin_o[PIN_SCK] = r.bclk;
            n.pin_oe[PIN_WS] = master;
            n.pin_o[PIN_WS] = r.ws;
            n.pin_oe[PIN_SDO] = 1'b1;
            n.pin_o[PIN_SDO] = I2S_SDO_BIT_IN;
        end

        n.spk_oe = n.ctrl[C_PD] ? 2'h0 : SPK_ON;
        n.miso_oe = sel;
        n.ready = (n.busy == '0);
        n.irq = |(n.irq_stat & n.irq_mask);
        n.irq_n = ~n.irq;

        // long high pulse on the reset pin
        if (r.pins.rst_s2) begin
            if (!dev_hold) begin
                n.hold_cnt = r.hold_cnt + 32'h1;
            end
        end else begin
            n.hold_cnt = '0;
        end
        if (dev_hold) begin
            k = n;
            n = S_RST;
            n.pins = k.pins;
            n.bus = k.bus;
            n.hold_cnt = k.hold_cnt;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            r <= S_RST;
        end else if (CE_IN) begin
            r <= n;
        end
    end

    assign PREADY_OUT = r.bus.pready;
    assign PSLVERR_OUT = r.bus.pslverr;
    assign PRDATA_OUT = r.bus.prdata;
    assign MISO_OUT = r.tx_sh[7];
    assign MISO_OE_OUT = r.miso_oe;
    assign TRANSFER_READY_OUT = r.ready;
    assign IRQ_OUT = r.irq;
    assign IRQ_REQUEST_N_OUT = r.irq_n;
    assign IRQ_REQUEST_N_OE_OUT = r.irq;
    assign GPIO_OUT_OUT = r.pin_o;
    assign GPIO_OE_OUT = r.pin_oe;
    assign SPK_OE_OUT = r.spk_oe;
    assign FLASH_ADDR_OUT = r.ptr[26:3];
    assign AUDIO_CFG_OUT = r.cfg;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!rst_n);

    a_miso_release: assert property (
        CE_IN && r.pins.ss_s2 |=> !MISO_OE_OUT)
        else $error("miso driven while deselected");
    a_deselect_idle: assert property (
        CE_IN && r.pins.ss_s2 |=> r.bit_cnt == '0 && r.byte_cnt == '0)
        else $error("serial state kept while deselected");
    a_busy_ready: assert property (
        CE_IN && r.busy > 4'h1 |=> !TRANSFER_READY_OUT)
        else $error("ready high while busy");
    a_hold_reset: assert property (
        CE_IN && r.hold_cnt >= 32'(DEV_RST_CYC) |=> r.ctrl == '0 && !r.rec && !IRQ_OUT)
        else $error("long reset pulse did not reset");
    a_irq_pin: assert property (
        (IRQ_REQUEST_N_OE_OUT == (|(r.irq_stat & r.irq_mask)))
        && (IRQ_REQUEST_N_OUT == !IRQ_REQUEST_N_OE_OUT))
        else $error("pending interrupt not signalled");
    a_i2s_dir: assert property (
        CE_IN && r.ctrl[C_I2S] && !dev_hold
        |=> GPIO_OE_OUT[PIN_SCK] == $past(master) && GPIO_OE_OUT[PIN_WS] == $past(master)
        && !GPIO_OE_OUT[PIN_SDI])
        else $error("i2s pin direction wrong");
    a_spk_off: assert property (
        r.ctrl[C_PD] |-> SPK_OE_OUT == 2'h0)
        else $error("speaker driven while powered down");
    a_rec_report: assert property (
        $fell(r.rec) && !$past(dev_hold)
        |-> r.rec_addr == $past(r.start) && r.irq_stat[EV_REC_DONE])
        else $error("recording end not reported");
    a_cfg_legal: assert property (
        cfg_ok(r.cfg))
        else $error("illegal audio configuration held");
endmodule
`default_nettype wire
